// *** common/pmrc_pkg.sv ***
package pmrc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses on apb)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PWR_A     = 8'h00;
	localparam logic [7:0] ADDR_PWR_B     = 8'h04;
	localparam logic [7:0] ADDR_REG_CTL   = 8'h08;
	localparam logic [7:0] ADDR_RST_SRC   = 8'h0C;
	localparam logic [7:0] ADDR_RETAIN    = 8'h10;
	localparam logic [7:0] ADDR_STATUS    = 8'h14;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_IDLE    = 0;
	localparam int BIT_POWEROFF = 1;
	localparam int BIT_SWRST   = 4;
	localparam int BIT_SUSP    = 0;
	localparam int BIT_SNOOZE  = 1;
	localparam int BIT_DSTOP   = 0;
	localparam int BIT_CLKSEL  = 0;

	// reset source bit order
	localparam int SRC_POR  = 0;
	localparam int SRC_PIN  = 1;
	localparam int SRC_CMP  = 2;
	localparam int SRC_SW   = 3;
	localparam int SRC_MON  = 4;
	localparam int SRC_WDT  = 5;
	localparam int SRC_MCD  = 6;
	localparam int SRC_FLSH = 7;
	localparam int N_SRC    = 8;
	localparam int N_WAKE   = 6;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
	localparam logic [7:0]  PORT_LATCH_RST = 8'hFF;
	localparam logic [15:0] PC_RST    = 16'h0000;

	// ----------------------------------------------------------------
	// timing, clock 20 mhz
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 20_000_000;
	localparam int POR_DLY_US    = 10_000;
	localparam int RST_DLY_US    = 50;
	localparam int SUSP_WK_NS    = 170;
	localparam int SNOOZE_WK_US  = 12;
	localparam int MCD_US        = 625;
	localparam int POR_CYC  = POR_DLY_US * (CLK_HZ / 1_000_000);
	localparam int RST_CYC  = RST_DLY_US * (CLK_HZ / 1_000_000);
	localparam int SUSP_CYC = (SUSP_WK_NS * (CLK_HZ / 1_000_000)
		+ 999) / 1000;
	localparam int SNZ_CYC  = SNOOZE_WK_US * (CLK_HZ / 1_000_000);
	localparam int MCD_CYC  = MCD_US * (CLK_HZ / 1_000_000);
	localparam int IDLE_WK_CYC = 2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum {
		PM_RESET, PM_RUN, PM_IDLE, PM_SUSPEND, PM_SNOOZE,
		PM_WAKE, PM_STOP, PM_SHUTDOWN
	} pmrc_mode_e;

	typedef struct packed {
		logic core_run;
		logic periph_clk;
		logic fast_osc_on;
		logic reg_low_bias;
		logic power_nets_on;
	} pmrc_pwr_s;

endpackage

// *** rtl/pmrc_ret_mem.sv ***
`timescale 1ns/1ns
// retention store: survives every reset except power-on
module pmrc_ret_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	input  wire logic             sys_clk,
	input  wire logic             por,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem_ff [DEPTH];

	// only power-on clears the words
	always_ff @(posedge sys_clk or posedge por) begin
		if (por) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
		end else if (we) begin
			mem_ff[waddr] <= wdata;
		end
	end

	// registered read port
	always_ff @(posedge sys_clk or posedge por) begin
		if (por) begin
			rdata <= '0;
		end else begin
			rdata <= mem_ff[raddr];
		end
	end
endmodule

// *** rtl/pmrc_top.sv ***
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ns
module pmrc_top #(
	parameter int POR_CYCLES = pmrc_pkg::POR_CYC,
	parameter int RST_CYCLES = pmrc_pkg::RST_CYC,
	parameter int MCD_CYCLES = pmrc_pkg::MCD_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        paddr_unused_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        irq_any,
	input  wire logic [5:0]  wake_evt,
	input  wire logic        reset_pin_n,
	input  wire logic        cmp_rst,
	input  wire logic        mon_rst,
	input  wire logic        wdt_rst,
	input  wire logic        flash_err,
	input  wire logic        slow_tick,
	output logic             reset_pin_n_out,
	output logic             reset_pin_n_oe,
	output logic             core_run,
	output logic             periph_clk_en,
	output logic             fast_osc_24m_en,
	output logic             fast_osc_72m_en,
	output logic             reg_low_bias,
	output logic             power_nets_on,
	output logic             slow_osc_80k_tmr_en,
	output logic             sys_rst,
	output logic             irq_tmr_dis,
	output logic             wdt_en,
	output logic             pc_clear,
	output logic [7:0]       port_latch,
	output logic             port_open_drain,
	output logic             port_pullup_en,
	output logic             retain_hold
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	pmrc_pkg::pmrc_mode_e mode_ff, nxt_mode;
	logic        idle_req_ff, susp_req_ff, snz_req_ff, poff_req_ff;
	logic        dstop_ff, clksel_ff, retain_ff;
	logic [7:0]  rst_src_ff;
	logic [31:0] wake_cnt_ff, rst_cnt_ff, mcd_cnt_ff;
	logic        por_ff, sw_rst_ff, in_reset_ff, pin_drv_ff;
	logic        wr_acc, rd_acc, store_rd;
	logic [31:0] ret_rdata;
	logic [7:0]  src_now;

	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] b);
		hit = (a == b);
	endfunction

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & ~penable & ~pwrite;
	// store reads need a cycle more: the memory read port is registered
	assign store_rd = psel & ~pwrite & (paddr[7:4] == 4'h2);

	// live reset sources in the fixed order; por comes from rst
	always_comb begin
		src_now = '0;
		src_now[pmrc_pkg::SRC_POR]  = por_ff;
		src_now[pmrc_pkg::SRC_PIN]  = ~reset_pin_n;
		src_now[pmrc_pkg::SRC_CMP]  = cmp_rst;
		src_now[pmrc_pkg::SRC_SW]   = sw_rst_ff;
		src_now[pmrc_pkg::SRC_MON]  = mon_rst;
		src_now[pmrc_pkg::SRC_WDT]  = wdt_rst;
		src_now[pmrc_pkg::SRC_MCD]  = mcd_cnt_ff >= 32'(MCD_CYCLES);
		src_now[pmrc_pkg::SRC_FLSH] = flash_err;
	end

	// ----------------------------------------------------------------
	// power-on stretch: first cycles after rst release
	// ----------------------------------------------------------------
	// rst stands for the por comparator; por_ff stays up for the delay
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			por_ff <= 1'b1;
		end else if (por_ff && rst_cnt_ff >= 32'(POR_CYCLES)) begin
			por_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// reset hold counter: por delay, or non-por delay for other sources
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rst_cnt_ff  <= '0;
			in_reset_ff <= 1'b1;
		end else if (|src_now[7:1] &&
			!(mode_ff == pmrc_pkg::PM_SHUTDOWN &&
			src_now[pmrc_pkg::SRC_PIN] == 1'b0)) begin
			rst_cnt_ff  <= '0; // source still asserted
			in_reset_ff <= 1'b1;
		end else if (por_ff) begin
			rst_cnt_ff  <= rst_cnt_ff + 32'd1;
		end else if (in_reset_ff) begin
			if (rst_cnt_ff >= 32'(RST_CYCLES)) begin
				in_reset_ff <= 1'b0;
				rst_cnt_ff  <= '0;
			end else begin
				rst_cnt_ff <= rst_cnt_ff + 32'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// missing clock detector
	// ----------------------------------------------------------------
	// counts fast clocks between slow_tick edges of the core clock
	// monitor; no tick in the window means the core clock is lost
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mcd_cnt_ff <= '0;
		end else if (slow_tick || in_reset_ff) begin
			mcd_cnt_ff <= '0;
		end else if (mcd_cnt_ff < 32'(MCD_CYCLES)) begin
			mcd_cnt_ff <= mcd_cnt_ff + 32'd1;
		end
	end

	// ----------------------------------------------------------------
	// reset source flags, sticky until cleared by writing ones
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rst_src_ff <= 8'h01;
		end else if (wr_acc && hit(paddr, pmrc_pkg::ADDR_RST_SRC)) begin
			rst_src_ff <= (rst_src_ff & ~pwdata[7:0]) | src_now; // set wins
		end else begin
			rst_src_ff <= rst_src_ff | src_now;
		end
	end

	// ----------------------------------------------------------------
	// control bits written by software
	// ----------------------------------------------------------------
	// requests self-clear when their mode ends, set wins over clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{idle_req_ff, susp_req_ff, snz_req_ff} <= '0;
			{poff_req_ff, dstop_ff, clksel_ff, sw_rst_ff} <= '0;
		end else if (in_reset_ff) begin
			{idle_req_ff, susp_req_ff, snz_req_ff} <= '0;
			{poff_req_ff, dstop_ff, clksel_ff, sw_rst_ff} <= '0;
		end else begin
			if (mode_ff == pmrc_pkg::PM_WAKE) begin
				{idle_req_ff, susp_req_ff, snz_req_ff} <= '0;
			end
			if (wr_acc && hit(paddr, pmrc_pkg::ADDR_PWR_A)) begin
				idle_req_ff <= pwdata[pmrc_pkg::BIT_IDLE];
				poff_req_ff <= pwdata[pmrc_pkg::BIT_POWEROFF];
				sw_rst_ff   <= pwdata[pmrc_pkg::BIT_SWRST];
			end
			if (wr_acc && hit(paddr, pmrc_pkg::ADDR_PWR_B)) begin
				susp_req_ff <= pwdata[pmrc_pkg::BIT_SUSP];
				snz_req_ff  <= pwdata[pmrc_pkg::BIT_SNOOZE];
			end
			if (wr_acc && hit(paddr, pmrc_pkg::ADDR_REG_CTL)) begin
				dstop_ff  <= pwdata[pmrc_pkg::BIT_DSTOP];
			end
			if (wr_acc && hit(paddr, pmrc_pkg::ADDR_STATUS)) begin
				clksel_ff <= pwdata[pmrc_pkg::BIT_CLKSEL];
			end
		end
	end

	// retention enable survives non-por resets
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			retain_ff <= 1'b0;
		end else if (wr_acc && hit(paddr, pmrc_pkg::ADDR_RETAIN)) begin
			retain_ff <= pwdata[0];
		end
	end

	// ----------------------------------------------------------------
	// power mode sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			pmrc_pkg::PM_RESET: begin
				if (!in_reset_ff) nxt_mode = pmrc_pkg::PM_RUN;
			end
			pmrc_pkg::PM_RUN: begin
				if (poff_req_ff) begin
					nxt_mode = dstop_ff ? pmrc_pkg::PM_SHUTDOWN
						: pmrc_pkg::PM_STOP;
				end else if (snz_req_ff) begin
					nxt_mode = pmrc_pkg::PM_SNOOZE;
				end else if (susp_req_ff) begin
					nxt_mode = pmrc_pkg::PM_SUSPEND;
				end else if (idle_req_ff) begin
					nxt_mode = pmrc_pkg::PM_IDLE;
				end
			end
			pmrc_pkg::PM_IDLE: begin
				if (irq_any) nxt_mode = pmrc_pkg::PM_WAKE;
			end
			pmrc_pkg::PM_SUSPEND, pmrc_pkg::PM_SNOOZE: begin
				if (|wake_evt) nxt_mode = pmrc_pkg::PM_WAKE;
			end
			pmrc_pkg::PM_WAKE: begin
				if (wake_cnt_ff <= 32'd1) nxt_mode = pmrc_pkg::PM_RUN;
			end
			default: nxt_mode = mode_ff;
		endcase
		if (in_reset_ff) nxt_mode = pmrc_pkg::PM_RESET;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_ff <= pmrc_pkg::PM_RESET;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// wake latency loaded on entry to the wake state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wake_cnt_ff <= '0;
		end else if (nxt_mode == pmrc_pkg::PM_WAKE &&
			mode_ff != pmrc_pkg::PM_WAKE) begin
			case (mode_ff)
				pmrc_pkg::PM_IDLE:
					wake_cnt_ff <= 32'(pmrc_pkg::IDLE_WK_CYC);
				pmrc_pkg::PM_SUSPEND:
					wake_cnt_ff <= 32'(pmrc_pkg::SUSP_CYC);
				default:
					wake_cnt_ff <= 32'(pmrc_pkg::SNZ_CYC);
			endcase
		end else if (wake_cnt_ff != '0) begin
			wake_cnt_ff <= wake_cnt_ff - 32'd1;
		end
	end

	// ----------------------------------------------------------------
	// power and clock outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{core_run, periph_clk_en, reg_low_bias} <= 3'b000;
			{fast_osc_24m_en, fast_osc_72m_en} <= 2'b10;
			{power_nets_on, slow_osc_80k_tmr_en} <= 2'b10;
		end else begin
			core_run <= nxt_mode == pmrc_pkg::PM_RUN;
			periph_clk_en <= nxt_mode inside {pmrc_pkg::PM_RUN,
				pmrc_pkg::PM_IDLE, pmrc_pkg::PM_WAKE};
			fast_osc_24m_en <= !(nxt_mode inside {pmrc_pkg::PM_SUSPEND,
				pmrc_pkg::PM_SNOOZE, pmrc_pkg::PM_STOP,
				pmrc_pkg::PM_SHUTDOWN});
			fast_osc_72m_en <= clksel_ff && nxt_mode inside
				{pmrc_pkg::PM_RUN, pmrc_pkg::PM_IDLE};
			reg_low_bias <= nxt_mode == pmrc_pkg::PM_SNOOZE;
			power_nets_on <= !(nxt_mode inside {pmrc_pkg::PM_STOP,
				pmrc_pkg::PM_SHUTDOWN});
			slow_osc_80k_tmr_en <= nxt_mode inside
				{pmrc_pkg::PM_SUSPEND, pmrc_pkg::PM_SNOOZE};
		end
	end

	// ----------------------------------------------------------------
	// reset actions: pins, pc, watchdog
	// ----------------------------------------------------------------
	// pins hold state in stop and shutdown, so only reset touches them
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{sys_rst, irq_tmr_dis, pc_clear, wdt_en} <= 4'b1110;
			port_latch      <= pmrc_pkg::PORT_LATCH_RST;
			port_open_drain <= 1'b1;
			port_pullup_en  <= 1'b1;
			retain_hold     <= 1'b0;
		end else begin
			sys_rst     <= in_reset_ff;
			irq_tmr_dis <= in_reset_ff;
			pc_clear    <= in_reset_ff;
			wdt_en      <= !in_reset_ff;
			retain_hold <= retain_ff && in_reset_ff;
			if (in_reset_ff && !retain_ff) begin
				port_latch      <= pmrc_pkg::PORT_LATCH_RST;
				port_open_drain <= 1'b1;
				port_pullup_en  <= 1'b1;
			end
		end
	end

	// reset pin driven low for monitor and power-on resets
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_drv_ff <= 1'b1;
		end else if (!in_reset_ff) begin
			pin_drv_ff <= 1'b0;
		end else if (por_ff || mon_rst) begin
			pin_drv_ff <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reset_pin_n_out <= 1'b0;
			reset_pin_n_oe  <= 1'b1;
		end else begin
			reset_pin_n_out <= 1'b0;
			reset_pin_n_oe  <= pin_drv_ff && in_reset_ff;
		end
	end

	// ----------------------------------------------------------------
	// retention store for port and analog settings
	// ----------------------------------------------------------------
	// cleared by power-on only; ram contents likewise survive resets
	pmrc_ret_mem #(.WIDTH(32), .DEPTH(4), .AW(2)) u_ret (
		.sys_clk (sys_clk),
		.por     (rst),
		.we      (wr_acc && paddr[7:4] == 4'h2),
		.waddr   (paddr[3:2]),
		.wdata   (pwdata),
		.raddr   (paddr[3:2]),
		.rdata   (ret_rdata)
	);

	// ----------------------------------------------------------------
	// apb slave: no wait state, one for reads of the store
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= store_rd ? (psel & penable & ~pready)
				: (psel & ~penable);
			pslverr <= psel & ~penable & ~store_rd & (paddr > 8'h2C);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata <= pmrc_pkg::RST_ZERO;
		end else if (rd_acc) begin
			prdata <= pmrc_pkg::RST_ZERO;
			case (paddr)
				pmrc_pkg::ADDR_PWR_A:
					prdata[1:0] <= {poff_req_ff, idle_req_ff};
				pmrc_pkg::ADDR_PWR_B:
					prdata[1:0] <= {snz_req_ff, susp_req_ff};
				pmrc_pkg::ADDR_REG_CTL: prdata[0] <= dstop_ff;
				pmrc_pkg::ADDR_RST_SRC: prdata[7:0] <= rst_src_ff;
				pmrc_pkg::ADDR_RETAIN:  prdata[0] <= retain_ff;
				pmrc_pkg::ADDR_STATUS:
					prdata[4:0] <= {mode_ff == pmrc_pkg::PM_RUN,
						in_reset_ff, por_ff, 1'b0, clksel_ff};
				default: ;
			endcase
		end else if (store_rd && penable && !pready) begin
			prdata <= ret_rdata; // word addressed since setup
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_idle_wake_time: assert property (@(posedge sys_clk)
		disable iff (rst) mode_ff == pmrc_pkg::PM_IDLE && irq_any
		&& !in_reset_ff |-> ##[2:3] core_run || in_reset_ff)
		else $error("idle wake too slow");
	a_susp_clk_off: assert property (@(posedge sys_clk)
		disable iff (rst) mode_ff == pmrc_pkg::PM_SUSPEND
		|-> !periph_clk_en && !fast_osc_24m_en)
		else $error("clocks running in suspend");
	a_snooze_bias: assert property (@(posedge sys_clk)
		disable iff (rst) mode_ff == pmrc_pkg::PM_SNOOZE |-> reg_low_bias)
		else $error("snooze without low bias");
	a_stop_power: assert property (@(posedge sys_clk)
		disable iff (rst) mode_ff == pmrc_pkg::PM_STOP |-> !power_nets_on)
		else $error("power nets on in stop");
	a_reset_pc: assert property (@(posedge sys_clk)
		disable iff (rst) $fell(in_reset_ff) |=> !pc_clear && wdt_en)
		else $error("no clean exit from reset");
	a_reset_actions: assert property (@(posedge sys_clk)
		disable iff (rst) in_reset_ff |=> sys_rst && irq_tmr_dis)
		else $error("reset actions missing");
	a_req_autoclr: assert property (@(posedge sys_clk)
		disable iff (rst) mode_ff == pmrc_pkg::PM_WAKE && nxt_mode ==
		pmrc_pkg::PM_RUN |=> !idle_req_ff && !susp_req_ff && !snz_req_ff)
		else $error("request bit not cleared");
	a_slow_tmr: assert property (@(posedge sys_clk)
		disable iff (rst) mode_ff inside {pmrc_pkg::PM_SUSPEND,
		pmrc_pkg::PM_SNOOZE} |-> slow_osc_80k_tmr_en)
		else $error("timer clock lost in sleep");
	c_idle: cover property (@(posedge sys_clk) mode_ff == pmrc_pkg::PM_IDLE);
	c_snooze: cover property (@(posedge sys_clk)
		mode_ff == pmrc_pkg::PM_SNOOZE);
	c_shutdown: cover property (@(posedge sys_clk)
		mode_ff == pmrc_pkg::PM_SHUTDOWN);
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ns
module tb;
	// ------------------------------------------------------------
	// stimulus, design and reference state
	// ------------------------------------------------------------
	localparam int PORC = 20;
	localparam int RSTC = 10;
	localparam int MCDC = 30;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        irq_any = 1'b0;
	logic [5:0]  wake_evt = 6'h00;
	logic [7:0]  src_v = 8'h00;
	logic        slow_tick = 1'b0;
	logic        tick_on = 1'b1;
	logic [31:0] prdata;
	logic        pready, pslverr, reset_pin_n_out, reset_pin_n_oe;
	logic        core_run, periph_clk_en, fast_osc_24m_en;
	logic        fast_osc_72m_en, reg_low_bias, power_nets_on;
	logic        slow_osc_80k_tmr_en, sys_rst, irq_tmr_dis, wdt_en;
	logic        pc_clear, port_open_drain, port_pullup_en, retain_hold;
	logic [7:0]  port_latch;
	wire         paddr_unused_n = 1'b1;
	wire         reset_pin_n = ~src_v[pmrc_pkg::SRC_PIN];
	wire         cmp_rst = src_v[pmrc_pkg::SRC_CMP];
	wire         mon_rst = src_v[pmrc_pkg::SRC_MON];
	wire         wdt_rst = src_v[pmrc_pkg::SRC_WDT];
	wire         flash_err = src_v[pmrc_pkg::SRC_FLSH];
	int          bad_count = 0;
	int          samples_checked = 0;
	logic [31:0] seed = 32'h224c_bd57;
	logic [31:0] store_q[$];
	int          n;
	int          src_list[4] = '{4, 5, 7, 3};

	pmrc_top #(.POR_CYCLES(PORC), .RST_CYCLES(RSTC), .MCD_CYCLES(MCDC))
	i_pmrc_top (.sys_clk, .rst, .paddr_unused_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_any,
		.wake_evt, .reset_pin_n, .cmp_rst, .mon_rst, .wdt_rst, .flash_err,
		.slow_tick, .reset_pin_n_out, .reset_pin_n_oe, .core_run,
		.periph_clk_en, .fast_osc_24m_en, .fast_osc_72m_en, .reg_low_bias,
		.power_nets_on, .slow_osc_80k_tmr_en, .sys_rst, .irq_tmr_dis,
		.wdt_en, .pc_clear, .port_latch, .port_open_drain, .port_pullup_en,
		.retain_hold);

	// 20 mhz clock
	always #25 sys_clk = ~sys_clk;

	// clock-life pulses, every other cycle while enabled
	always @(posedge sys_clk) slow_tick <= tick_on & ~slow_tick;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic tally_and_finish();
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("ERROR %0t latency %0d not in %0d..%0d", $time, got,
				lo, hi);
		end
	endtask

	// one apb transfer; an edge always passes before psel rises again
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			bad_count++;
			$display("ERROR %0t no pready on the bus", $time);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(r, exp);
	endtask

	// edges until core_run is seen high, bounded
	task automatic wait_run(output int c);
		c = 0;
		do begin
			@(posedge sys_clk);
			c++;
		end while (core_run !== 1'b1 && c < 2000);
		if (core_run !== 1'b1) begin
			bad_count++;
			$display("ERROR %0t core never ran again", $time);
		end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		int s, c;
		logic [31:0] d;
		logic        e1;
		repeat (12) @(posedge sys_clk);
		chk({sys_rst, core_run, irq_tmr_dis}, 3'b101);
		chk({port_latch, port_open_drain, port_pullup_en},
			{pmrc_pkg::PORT_LATCH_RST, 2'b11});
		chk(reset_pin_n_oe, 1'b1);
		rst <= 1'b0;
		wait_run(n);
		chk_rng(n, PORC, PORC + 4);
		chk({wdt_en, pc_clear, reset_pin_n_oe}, 3'b100);
		rd(pmrc_pkg::ADDR_RST_SRC, 32'h0000_0001);
		wr(pmrc_pkg::ADDR_RST_SRC, 32'h0000_00FF);
		// idle: peripherals stay clocked, an interrupt resumes
		wr(pmrc_pkg::ADDR_PWR_A, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		chk({core_run, periph_clk_en}, 2'b01);
		irq_any <= 1'b1;
		wait_run(n);
		irq_any <= 1'b0;
		chk_rng(n - 1, 2, 3);
		rd(pmrc_pkg::ADDR_PWR_A, 32'h0000_0000);
		// fast 72 mhz clock selectable in run, then back to 24.5 mhz
		wr(pmrc_pkg::ADDR_STATUS, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		chk(fast_osc_72m_en, 1'b1);
		wr(pmrc_pkg::ADDR_STATUS, 32'h0000_0000);
		// suspend then snooze, every wake event, random order start
		for (int m = 0; m < 2; m++) begin
			s = xs() % 6;
			for (int e = 0; e < 6; e++) begin
				wr(pmrc_pkg::ADDR_PWR_B, 32'(1 << m));
				repeat (2) @(posedge sys_clk);
				chk({core_run, periph_clk_en, fast_osc_24m_en,
					fast_osc_72m_en}, 4'h0);
				chk(reg_low_bias, m[0]);
				chk(slow_osc_80k_tmr_en, 1'b1);
				wake_evt <= 6'(1 << ((s + e) % 6));
				wait_run(n);
				wake_evt <= 6'h00;
				c = (m == 0) ? pmrc_pkg::SUSP_CYC : pmrc_pkg::SNZ_CYC;
				chk_rng(n - 1, c, c + 2);
				rd(pmrc_pkg::ADDR_PWR_B, 32'h0000_0000);
			end
		end
		// retention armed, a word kept in the store
		wr(pmrc_pkg::ADDR_RETAIN, 32'h0000_0001);
		d = xs();
		store_q.push_back(d);
		wr(8'h20, d);
		// stop mode, left by a comparator reset
		wr(pmrc_pkg::ADDR_REG_CTL, 32'h0000_0000);
		wr(pmrc_pkg::ADDR_PWR_A, 32'h0000_0002);
		repeat (2) @(posedge sys_clk);
		chk({power_nets_on, core_run}, 2'b00);
		src_v <= 8'h04;
		repeat (3) @(posedge sys_clk);
		src_v <= 8'h00;
		wait_run(n);
		rd(pmrc_pkg::ADDR_RST_SRC, 32'h0000_0004);
		wr(pmrc_pkg::ADDR_RST_SRC, 32'h0000_00FF);
		// shutdown ignores a watchdog reset, ends on the pin
		wr(pmrc_pkg::ADDR_REG_CTL, 32'h0000_0001);
		wr(pmrc_pkg::ADDR_PWR_A, 32'h0000_0002);
		// let shutdown be entered first, else the watchdog still resets
		repeat (2) @(posedge sys_clk);
		src_v <= 8'h20;
		repeat (3) @(posedge sys_clk);
		src_v <= 8'h00;
		repeat (40) @(posedge sys_clk);
		chk({power_nets_on, core_run}, 2'b00);
		src_v <= 8'h02;
		repeat (300) @(posedge sys_clk);
		src_v <= 8'h00;
		wait_run(n);
		chk(core_run, 1'b1);
		wr(pmrc_pkg::ADDR_RST_SRC, 32'h0000_00FF);
		wr(pmrc_pkg::ADDR_REG_CTL, 32'h0000_0000);
		// remaining sources, each seen alone in the flags
		foreach (src_list[i]) begin
			s = src_list[i];
			if (s == pmrc_pkg::SRC_SW)
				wr(pmrc_pkg::ADDR_PWR_A, 32'h0000_0010);
			else
				src_v <= 8'(1 << s);
			// pin enable is two flops behind the reset entry
			repeat (4) @(posedge sys_clk);
			chk({sys_rst, retain_hold}, 2'b11);
			chk({reset_pin_n_oe, reset_pin_n_out},
				{s == pmrc_pkg::SRC_MON, 1'b0});
			src_v <= 8'h00;
			wait_run(n);
			chk_rng(n, RSTC, RSTC + 4);
			rd(pmrc_pkg::ADDR_RST_SRC, 32'(1 << s));
			wr(pmrc_pkg::ADDR_RST_SRC, 32'h0000_00FF);
		end
		rd(8'h20, store_q.pop_front());
		// missing clock: pulses stop, reset after the count
		tick_on <= 1'b0;
		c = 0;
		do begin
			@(posedge sys_clk);
			c++;
		end while (sys_rst !== 1'b1 && c < 200);
		chk_rng(c, MCDC, MCDC + 5);
		tick_on <= 1'b1;
		wait_run(n);
		rd(pmrc_pkg::ADDR_RST_SRC, 32'h0000_0040);
		// unmapped place answers zero with an error
		apb(1'b0, 8'h30, 32'h0000_0000, d, e1);
		chk(d, 32'h0000_0000);
		chk(e1, 1'b1);
		tally_and_finish();
	end

	// hang guard, far beyond the expected run length
	initial begin
		#(50 * 40000);
		bad_count++;
		tally_and_finish();
	end
endmodule
